// ---- rtl/shift_port_device.sv ----
// Behaviour
// - Shift and count on falling clock edges
// - Eight-bit shift register, four-bit counter
// - Data moves most significant bit first
// - After eight pulses, stop clocking everything
// - Interrupt on eighth falling edge
// - Data write clears counter, enables interrupt
// - Any write to disable location disables
// - Interrupt disabled after reset
// - Slave mode: clock pin is input
// - Master: peer toggles clock line
// - Input pin input, output open-drain
// - Data lines may be tied together
// - Clock may come from timer pin
`timescale 1ns/1ps
module shift_port_device
    import shift_port_pkg::*;
(
    input  wire logic                         clk_sys_in,
    input  wire logic                         rst_n_in,
    input  wire logic                         clk_en_in,
    shift_port_if.device                      link,
    input  wire logic [shift_port_pkg::ADDR_W-1:0] addr_in,
    input  wire logic                         wr_en_in,
    input  wire logic                         rd_en_in,
    input  wire logic [shift_port_pkg::DATA_W-1:0] wr_data_in,
    output logic      [shift_port_pkg::DATA_W-1:0] rd_data_out,
    output logic                              irq_out,
    output logic                              count_done_n_out
);
    import shift_port_pkg::*;

    logic [2:0]        clk_sync_reg;
    logic [2:0]        clk_sync_next;
    logic [1:0]        sin_sync_reg;
    logic [1:0]        sin_sync_next;
    logic [DATA_W-1:0] shift_reg;
    logic [DATA_W-1:0] shift_next;
    logic [CNT_W-1:0]  count_reg;
    logic [CNT_W-1:0]  count_next;
    logic [CNT_W-1:0]  count_inc;
    logic              int_en_reg;
    logic              int_en_next;
    logic              irq_reg;
    logic              irq_next;
    logic [DATA_W-1:0] rd_reg;
    logic [DATA_W-1:0] rd_next;
    logic              fall;
    logic              wr_data;
    logic              wr_dis;
    logic              step;
    logic              last_step;

    // Terminal count and register width must agree
    if (int'(CNT_DONE) != DATA_W || DATA_W < 2) begin : g_bad_width
        $error("terminal count must equal data width");
    end

    // Both locations must be distinct
    if (ADDR_SHIFT_DATA == ADDR_INT_DIS) begin : g_bad_addr
        $error("register locations overlap");
    end

    // Address decode for the data location
    function automatic logic sel_data(
        input logic [ADDR_W-1:0] addr
    );
        return addr == ADDR_SHIFT_DATA;
    endfunction

    // Address decode for the disable location
    function automatic logic sel_dis(
        input logic [ADDR_W-1:0] addr
    );
        return addr == ADDR_INT_DIS;
    endfunction

    // Eight pulses counted
    function automatic logic is_full(
        input logic [CNT_W-1:0] cnt
    );
        return cnt == CNT_DONE;
    endfunction

    assign wr_data   = wr_en_in && sel_data(addr_in);
    assign wr_dis    = wr_en_in && sel_dis(addr_in);
    assign fall      = clk_sync_reg[2] & ~clk_sync_reg[1];
    assign count_inc = count_reg + 4'h1;
    assign step      = fall && !wr_data && !is_full(count_reg);
    assign last_step = step && is_full(count_inc);

    // Clock pin synchroniser and edge detector
    always_comb begin
        clk_sync_next = {clk_sync_reg[1:0], link.shift_clock_pin};
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_sync_reg <= 3'h7;
        end else if (clk_en_in) begin
            clk_sync_reg <= clk_sync_next;
        end
    end

    // Data pin synchroniser
    always_comb begin
        sin_sync_next = {sin_sync_reg[0], link.serial_in_pin};
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sin_sync_reg <= 2'h3;
        end else if (clk_en_in) begin
            sin_sync_reg <= sin_sync_next;
        end
    end

    // Shift register: load on write, shift on clock fall
    always_comb begin
        shift_next = shift_reg;
        if (wr_data) begin
            shift_next = wr_data_in;
        end else if (step) begin
            shift_next = {shift_reg[DATA_W-2:0], sin_sync_reg[1]};
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_reg <= DATA_RESET;
        end else if (clk_en_in) begin
            shift_reg <= shift_next;
        end
    end

    // Bit counter: cleared on write, stops at eight
    always_comb begin
        count_next = count_reg;
        if (wr_data) begin
            count_next = CNT_RESET;
        end else if (step) begin
            count_next = count_inc;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= CNT_DONE;
        end else if (clk_en_in) begin
            count_reg <= count_next;
        end
    end

    // Interrupt enable
    always_comb begin
        int_en_next = int_en_reg;
        if (wr_data) begin
            int_en_next = 1'b1;
        end
        if (wr_dis) begin
            int_en_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_en_reg <= 1'b0;
        end else if (clk_en_in) begin
            int_en_reg <= int_en_next;
        end
    end

    // End-of-transfer pulse
    always_comb begin
        irq_next = 1'b0;
        if (last_step) begin
            irq_next = int_en_reg;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_reg <= 1'b0;
        end else if (clk_en_in) begin
            irq_reg <= irq_next;
        end
    end

    // Read data, other locations read zero
    always_comb begin
        rd_next = rd_reg;
        if (rd_en_in) begin
            rd_next = sel_data(addr_in) ? shift_reg : DATA_RESET;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_reg <= DATA_RESET;
        end else if (clk_en_in) begin
            rd_reg <= rd_next;
        end
    end

    // Open-drain output: drive only a low
    assign link.sout_drv    = 1'b0;
    assign link.sout_oe_n   = shift_reg[DATA_W-1];
    assign rd_data_out      = rd_reg;
    assign irq_out          = irq_reg;
    assign count_done_n_out = ~is_full(count_reg);
endmodule

// ---- rtl/shift_port_pkg.sv ----
package shift_port_pkg;
    localparam int          DATA_W          = 8;
    localparam int          CNT_W           = 4;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  ADDR_INT_DIS    = 8'hdc;
    localparam logic [7:0]  ADDR_SHIFT_DATA = 8'hdd;
    localparam logic [3:0]  CNT_DONE        = 4'h8;
    localparam logic [3:0]  CNT_RESET       = 4'h0;
    localparam logic [7:0]  DATA_RESET      = 8'h00;
    localparam int          HOST_DIV_HALF   = 8;
    localparam int          DIV_W           = 8;
endpackage

// ---- rtl/shift_port_if.sv ----
`timescale 1ns/1ps
interface shift_port_if;
    logic clk_drv;
    logic clk_oe_n;
    logic sin_level;
    logic sout_drv;
    logic sout_oe_n;
    logic host_data;
    logic host_data_oe_n;
    logic shift_clock_pin;
    logic serial_in_pin;
    logic serial_out_pin;

    assign shift_clock_pin = clk_oe_n ? 1'b1 : clk_drv;
    assign serial_out_pin  = (sout_oe_n ? 1'b1 : sout_drv)
                           & (host_data_oe_n ? 1'b1 : host_data);
    assign serial_in_pin   = serial_out_pin;

    modport device (
        input  shift_clock_pin,
        input  serial_in_pin,
        output sout_drv,
        output sout_oe_n
    );
    modport host (
        input  serial_out_pin,
        output clk_drv,
        output clk_oe_n,
        output host_data,
        output host_data_oe_n
    );
endinterface

// ---- rtl/shift_port_host.sv ----
`timescale 1ns/1ps
module shift_port_host
    import shift_port_pkg::*;
#(
    parameter int HALF_PERIOD = shift_port_pkg::HOST_DIV_HALF
)
(
    input  wire logic                         clk_sys_in,
    input  wire logic                         rst_n_in,
    input  wire logic                         clk_en_in,
    shift_port_if.host                        link,
    input  wire logic                         master_in,
    input  wire logic                         start_in,
    input  wire logic [shift_port_pkg::DATA_W-1:0] tx_data_in,
    output logic                              busy_out,
    output logic                              done_out,
    output logic      [shift_port_pkg::DATA_W-1:0] rx_data_out
);
    import shift_port_pkg::*;

    if (HALF_PERIOD < 2 || HALF_PERIOD > 255) begin : g_bad_half
        $error("HALF_PERIOD out of range");
    end

    typedef enum logic [2:0] {
        IDLE = 3'b001,
        LOW  = 3'b010,
        HIGH = 3'b100
    } host_state_t;

    host_state_t       state_reg, state_next;
    logic [DIV_W-1:0]  div_reg,   div_next;
    logic [3:0]        bit_reg,   bit_next;
    logic [DATA_W-1:0] tx_reg,    tx_next;
    logic [DATA_W-1:0] rx_reg,    rx_next;
    logic              clk_reg,   clk_next;
    logic              done_reg,  done_next;
    logic [1:0]        din_sync_reg, din_sync_next;
    logic              tick;

    assign tick = (div_reg == DIV_W'(HALF_PERIOD - 1));

    always_comb begin
        state_next    = state_reg;
        div_next      = tick ? '0 : div_reg + 8'h01;
        bit_next      = bit_reg;
        tx_next       = tx_reg;
        rx_next       = rx_reg;
        clk_next      = clk_reg;
        done_next     = 1'b0;
        din_sync_next = {din_sync_reg[0], link.serial_out_pin};
        unique case (state_reg)
            IDLE: begin
                div_next = '0;
                clk_next = 1'b1;
                if (start_in) begin
                    tx_next    = tx_data_in;
                    bit_next   = 4'h0;
                    state_next = HIGH;
                end
            end
            HIGH: begin
                if (tick) begin
                    if (bit_reg == CNT_DONE) begin
                        state_next = IDLE;
                        done_next  = 1'b1;
                    end else begin
                        clk_next   = 1'b0;
                        rx_next    = {rx_reg[DATA_W-2:0], din_sync_reg[1]};
                        state_next = LOW;
                    end
                end
            end
            LOW: begin
                if (tick) begin
                    clk_next   = 1'b1;
                    tx_next    = {tx_reg[DATA_W-2:0], 1'b1};
                    bit_next   = bit_reg + 4'h1;
                    state_next = HIGH;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg    <= IDLE;
            div_reg      <= '0;
            bit_reg      <= 4'h0;
            tx_reg       <= 8'hff;
            rx_reg       <= 8'h00;
            clk_reg      <= 1'b1;
            done_reg     <= 1'b0;
            din_sync_reg <= 2'h3;
        end else if (clk_en_in) begin
            state_reg    <= state_next;
            div_reg      <= div_next;
            bit_reg      <= bit_next;
            tx_reg       <= tx_next;
            rx_reg       <= rx_next;
            clk_reg      <= clk_next;
            done_reg     <= done_next;
            din_sync_reg <= din_sync_next;
        end
    end

    assign link.clk_drv        = clk_reg;
    assign link.clk_oe_n       = ~master_in;
    assign link.host_data      = 1'b0;
    assign link.host_data_oe_n = tx_reg[DATA_W-1];
    assign busy_out            = (state_reg != IDLE);
    assign done_out            = done_reg;
    assign rx_data_out         = rx_reg;
endmodule

// ---- tb/shift_port_properties.sv ----
`timescale 1ns/1ps
module shift_port_properties
    import shift_port_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    input  wire logic       shift_clock_pin,
    input  wire logic       sout_drv,
    input  wire logic       sout_oe_n,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] rd_data_out,
    input  wire logic       irq_out,
    input  wire logic       count_done_n_out
);
    logic [3:0] since_reg;
    logic [3:0] since_next;
    logic       pin_reg;
    logic       wr_dd;
    assign wr_dd = wr_en_in && addr_in == ADDR_SHIFT_DATA;
    // Cycles since last clock fall or data write
    always_comb begin
        since_next = since_reg + {3'h0, since_reg != 4'hf};
        if ((pin_reg && !shift_clock_pin) || wr_dd) begin
            since_next = 4'h0;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            since_reg <= 4'hf;
            pin_reg   <= 1'b1;
        end else begin
            since_reg <= since_next;
            pin_reg   <= shift_clock_pin;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_od_low; !sout_oe_n |-> !sout_drv; endproperty
    a_od_low: assert property (p_od_low) else $error("serial out driven high");
    property p_reset_state; $rose(rst_n_in) |-> !sout_oe_n && !count_done_n_out; endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_wr_clear; wr_dd |=> count_done_n_out; endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("write kept counter done");
    property p_stop; !count_done_n_out && !wr_dd |=> !count_done_n_out; endproperty
    a_stop: assert property (p_stop) else $error("counter ran past eight");
    property p_irq_done; irq_out |-> !count_done_n_out; endproperty
    a_irq_done: assert property (p_irq_done) else $error("irq before eighth edge");
    property p_irq_pulse; irq_out |=> !irq_out; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq repeated");
    property p_dis_read; rd_en_in && addr_in == ADDR_INT_DIS |=> rd_data_out == 8'h00; endproperty
    a_dis_read: assert property (p_dis_read) else $error("disable location readable");
    property p_shift_cause; $changed(sout_oe_n) |-> since_reg <= 4'h6; endproperty
    a_shift_cause: assert property (p_shift_cause) else $error("shift without clock fall");
endmodule

// ---- tb/test_sync_serial_shift_port.sv ----
`timescale 1ns/1ps
module test_sync_serial_shift_port;
    import shift_port_pkg::*;
    logic       clk_sys_in = 1'b0;
    logic       rst_n_in   = 1'b0;
    logic [7:0] addr_in    = 8'h00;
    logic       wr_en_in   = 1'b0;
    logic       rd_en_in   = 1'b0;
    logic [7:0] wr_data_in = 8'h00;
    logic       start_in   = 1'b0;
    logic [7:0] tx_data_in = 8'hff;
    logic [7:0] rd_data_out;
    logic [7:0] rx_data_out;
    logic [7:0] got;
    logic       irq_out;
    logic       count_done_n_out;
    logic       busy_out;
    logic       done_out;
    logic       clk_en_in  = 1'b1;
    logic       master_in  = 1'b1;
    int         n_errors   = 0;
    int         n_compared = 0;
    int         n_irq      = 0;
    int         n_done     = 0;
    int         cycles     = 0;
    shift_port_if shift_port_if_i ();
    shift_port_device shift_port_device_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in), .link(shift_port_if_i), .addr_in(addr_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
        .irq_out(irq_out), .count_done_n_out(count_done_n_out));
    shift_port_host shift_port_host_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in), .link(shift_port_if_i), .master_in(master_in),
        .start_in(start_in), .tx_data_in(tx_data_in), .busy_out(busy_out),
        .done_out(done_out), .rx_data_out(rx_data_out));
    shift_port_properties shift_port_properties_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .shift_clock_pin(shift_port_if_i.shift_clock_pin), .sout_drv(shift_port_if_i.sout_drv),
        .sout_oe_n(shift_port_if_i.sout_oe_n), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .addr_in(addr_in), .rd_data_out(rd_data_out), .irq_out(irq_out),
        .count_done_n_out(count_done_n_out));
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(negedge clk_sys_in) begin
        cycles++;
        if (irq_out === 1'b1) n_irq++;
        if (done_out === 1'b1) n_done++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clk_sys_in);
        addr_in = a;
        wr_data_in = d;
        wr_en_in = w;
        rd_en_in = !w;
        @(negedge clk_sys_in);
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        @(negedge clk_sys_in);
        got = rd_data_out;
    endtask
    task automatic xfer(input logic [7:0] t);
        int n;
        n = n_done;
        @(negedge clk_sys_in);
        tx_data_in = t;
        start_in = 1'b1;
        @(negedge clk_sys_in);
        start_in = 1'b0;
        for (int i = 0; i < 400 && busy_out !== 1'b0; i++) @(negedge clk_sys_in);
        repeat (8) @(negedge clk_sys_in);
        chk({7'h0, busy_out}, 8'h00);
        chk(8'(n_done - n), 8'h01);
    endtask
    task automatic t_after_reset();
        chk({7'h0, count_done_n_out}, 8'h00);
        xfer(8'h5a);
        chk(n_irq[7:0], 8'h00);
        acc(ADDR_SHIFT_DATA, 8'h00, 1'b0);
        chk(got, DATA_RESET);
    endtask
    task automatic t_exchange(input logic [7:0] d, input logic [7:0] t);
        n_irq = 0;
        acc(ADDR_SHIFT_DATA, d, 1'b1);
        chk({7'h0, count_done_n_out}, 8'h01);
        xfer(t);
        chk(rx_data_out, d & t);
        acc(ADDR_SHIFT_DATA, 8'h00, 1'b0);
        chk(got, d & t);
        chk(n_irq[7:0], 8'h01);
        chk({7'h0, count_done_n_out}, 8'h00);
        xfer(8'h00);
        acc(ADDR_SHIFT_DATA, 8'h00, 1'b0);
        chk(got, d & t);
        chk(n_irq[7:0], 8'h01);
        acc(ADDR_INT_DIS, 8'h00, 1'b0);
        chk(got, 8'h00);
        acc(8'h10, 8'h00, 1'b0);
        chk(got, 8'h00);
    endtask
    task automatic t_slave();
        n_irq = 0;
        acc(ADDR_SHIFT_DATA, 8'h81, 1'b1);
        master_in = 1'b0;
        xfer(8'h00);
        master_in = 1'b1;
        chk(n_irq[7:0], 8'h00);
        acc(ADDR_SHIFT_DATA, 8'h00, 1'b0);
        chk(got, 8'h81);
    endtask
    task automatic t_clken();
        clk_en_in = 1'b0;
        acc(ADDR_SHIFT_DATA, 8'h3c, 1'b1);
        clk_en_in = 1'b1;
        acc(ADDR_SHIFT_DATA, 8'h00, 1'b0);
        chk(got, 8'h81);
    endtask
    task automatic t_disable();
        n_irq = 0;
        acc(ADDR_SHIFT_DATA, 8'hc3, 1'b1);
        acc(ADDR_INT_DIS, 8'h5a, 1'b1);
        xfer(8'hff);
        chk(n_irq[7:0], 8'h00);
        acc(ADDR_SHIFT_DATA, 8'h00, 1'b0);
        chk(got, 8'hc3);
    endtask
    task automatic t_reset_mid();
        n_irq = 0;
        acc(ADDR_SHIFT_DATA, 8'h96, 1'b1);
        rst_n_in = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        chk({7'h0, count_done_n_out}, 8'h00);
        xfer(8'h00);
        chk(n_irq[7:0], 8'h00);
        acc(ADDR_SHIFT_DATA, 8'h00, 1'b0);
        chk(got, DATA_RESET);
    endtask
    initial begin
        repeat (5) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        t_after_reset();
        t_exchange(8'ha5, 8'h3c);
        t_exchange(8'hff, 8'h1e);
        t_slave();
        t_clken();
        t_disable();
        t_reset_mid();
        end_of_test();
    end
endmodule
